// ### srfd_map.svh
`ifndef SRFD_MAP_SVH
`define SRFD_MAP_SVH

// register indices; byte address is four times the index
`define SRFD_IDX_DIVIDE   7'h18
`define SRFD_IDX_POWER    7'h19
`define SRFD_IDX_PULSE    7'h1a
`define SRFD_IDX_PHASE    7'h1b
`define SRFD_IDX_MODHI    7'h1c
`define SRFD_IDX_MODLO    7'h1f
`define SRFD_IDX_SINGLE   7'h70
`define SRFD_IDX_STATUS   7'h71

// reset values
`define SRFD_RST_DIVIDE   8'h00
`define SRFD_RST_POWER    8'h44
`define SRFD_RST_PULSE    8'h00
`define SRFD_RST_PHASE    8'h00
`define SRFD_RST_MODHI    8'h00
`define SRFD_RST_MODLO    8'h00
`define SRFD_RST_SINGLE   8'h00

// reserved bits read as zero
`define SRFD_MASK_MODHI   8'hf7
`define SRFD_MASK_SINGLE  8'h80

// field positions of the divide setting and of the power-down bit
`define SRFD_TOP_HI       7
`define SRFD_TOP_LO       6
`define SRFD_UPR_HI       5
`define SRFD_UPR_LO       4
`define SRFD_BIT3         3
`define SRFD_BIT2         2
`define SRFD_LOW_HI       1
`define SRFD_LOW_LO       0
`define SRFD_PD_BIT       7

// ratio constants
`define SRFD_RATIO_TWO    5'h02
`define SRFD_RATIO_FOUR   5'h04
`define SRFD_FINAL_DIV    16'h0002

`endif

// ### srfd_pkg.sv
package srfd_pkg;

  typedef logic [4:0] srfd_ratio_t;

  typedef struct packed {
    srfd_ratio_t top;
    srfd_ratio_t upper;
    srfd_ratio_t bit3;
    srfd_ratio_t bit2;
    srfd_ratio_t low;
  } srfd_ratios_s;

  typedef struct packed {
    logic [7:0] active;
    logic       running;
    logic       level;
  } srfd_status_s;

  typedef enum logic {
    ST_OFF = 1'b0,
    ST_RUN = 1'b1
  } srfd_state_e;

endpackage

// ### srfd_decode.sv
`timescale 1ns/100ps
`include "srfd_map.svh"

module srfd_decode (
  input  wire logic                 [7:0] setting, // divide setting
  output srfd_pkg::srfd_ratios_s          ratios   // per-stage ratios
);
  import srfd_pkg::*;

  always_comb begin
    ratios.top   = srfd_ratio_t'(`SRFD_RATIO_TWO << setting[`SRFD_TOP_HI:`SRFD_TOP_LO]);
    ratios.upper = srfd_ratio_t'({3'h0, setting[`SRFD_UPR_HI:`SRFD_UPR_LO]}) + `SRFD_RATIO_TWO;
    ratios.bit3  = setting[`SRFD_BIT3] ? `SRFD_RATIO_FOUR : `SRFD_RATIO_TWO;
    ratios.bit2  = setting[`SRFD_BIT2] ? `SRFD_RATIO_FOUR : `SRFD_RATIO_TWO;
    ratios.low   = srfd_ratio_t'({3'h0, setting[`SRFD_LOW_HI:`SRFD_LOW_LO]}) + `SRFD_RATIO_TWO;
  end

endmodule

// ### srfd_stage.sv
`timescale 1ns/100ps

module srfd_stage (
  input  wire logic                        pclk,    // clock
  input  wire logic                        presetn, // async reset, low
  input  wire logic                        clr,     // hold count at zero
  input  wire logic                        tick_i,  // advance enable
  input  wire srfd_pkg::srfd_ratio_t       ratio,   // divide ratio
  output logic                             tick_o   // terminal tick
);
  import srfd_pkg::*;

  logic [3:0] count_q;
  logic [3:0] count_d;
  logic [3:0] last;

  always_comb begin
    last    = 4'(ratio - 5'h01);
    tick_o  = tick_i && (count_q == last);
    count_d = count_q;
    if (clr) begin
      count_d = 4'h0;
    end else if (tick_i) begin
      count_d = (count_q == last) ? 4'h0 : 4'(count_q + 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ### srfd_top.sv
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "srfd_map.svh"

// How it works
// - The output period is two times the product of the five stage ratios, 64 at reset.
// - The top two setting bits pick a stage ratio of 2, 4, 8 or 16.
// - Bits 5:4 and 1:0 pick 2 to 5, and bits 3 and 2 each pick 2 or 4.
// - The divider runs while the power-down bit is 0 and stops when it is 1.
module srfd_top (
  input  wire logic                  pclk,           // clock, 200 MHz
  input  wire logic                  presetn,        // async reset, low
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb enable
  input  wire logic                  pwrite,         // apb direction
  input  wire logic           [11:0] paddr,          // apb byte address
  input  wire logic           [31:0] pwdata,         // apb write data
  output logic                [31:0] prdata,         // apb read data
  output logic                       pready,         // apb ready
  output logic                       pslverr,        // apb error
  output logic                       sysref_out,     // divided reference
  output logic                       sysref_powered  // reference blocks running
);
  import srfd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [7:0]   divide_q, divide_d;
  logic [7:0]   power_q, power_d;
  logic [7:0]   pulse_q, pulse_d;
  logic [7:0]   phase_q, phase_d;
  logic [7:0]   modhi_q, modhi_d;
  logic [7:0]   modlo_q, modlo_d;
  logic [7:0]   single_q, single_d;
  logic [31:0]  prdata_q, prdata_d;
  logic [6:0]   idx;
  logic         aligned;
  logic         hit;
  logic         wr_en;
  logic [7:0]   wbyte;
  logic [7:0]   rbyte;
  srfd_status_s status;

  assign idx     = paddr[8:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:9] == 3'h0);
  assign wbyte   = pwdata[7:0];
  assign wr_en   = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  always_comb begin
    hit   = aligned;
    rbyte = 8'h00;
    case (idx)
      `SRFD_IDX_DIVIDE: rbyte = divide_q;
      `SRFD_IDX_POWER:  rbyte = power_q;
      `SRFD_IDX_PULSE:  rbyte = pulse_q;
      `SRFD_IDX_PHASE:  rbyte = phase_q;
      `SRFD_IDX_MODHI:  rbyte = modhi_q;
      `SRFD_IDX_MODLO:  rbyte = modlo_q;
      `SRFD_IDX_SINGLE: rbyte = single_q;
      `SRFD_IDX_STATUS: rbyte = 8'h00;
      default:          hit   = 1'b0;
    endcase
  end

  always_comb begin
    divide_d = divide_q;
    power_d  = power_q;
    pulse_d  = pulse_q;
    phase_d  = phase_q;
    modhi_d  = modhi_q;
    modlo_d  = modlo_q;
    single_d = single_q;
    prdata_d = prdata_q;
    if (wr_en) begin
      case (idx)
        `SRFD_IDX_DIVIDE: divide_d = wbyte;
        `SRFD_IDX_POWER:  power_d  = wbyte;
        `SRFD_IDX_PULSE:  pulse_d  = wbyte;
        `SRFD_IDX_PHASE:  phase_d  = wbyte;
        `SRFD_IDX_MODHI:  modhi_d  = wbyte & `SRFD_MASK_MODHI;
        `SRFD_IDX_MODLO:  modlo_d  = wbyte;
        `SRFD_IDX_SINGLE: single_d = wbyte & `SRFD_MASK_SINGLE;
        default:          divide_d = divide_q;
      endcase
    end
    // read data captured in setup so it comes from a flip-flop
    if (psel && !penable && !pwrite) begin
      if (hit && (idx == `SRFD_IDX_STATUS)) begin
        prdata_d = {22'h0, status};
      end else begin
        prdata_d = {24'h0, rbyte};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divide_q <= `SRFD_RST_DIVIDE;
      power_q  <= `SRFD_RST_POWER;
      pulse_q  <= `SRFD_RST_PULSE;
      phase_q  <= `SRFD_RST_PHASE;
      modhi_q  <= `SRFD_RST_MODHI;
      modlo_q  <= `SRFD_RST_MODLO;
      single_q <= `SRFD_RST_SINGLE;
      prdata_q <= 32'h0;
    end else begin
      divide_q <= divide_d;
      power_q  <= power_d;
      pulse_q  <= pulse_d;
      phase_q  <= phase_d;
      modhi_q  <= modhi_d;
      modlo_q  <= modlo_d;
      single_q <= single_d;
      prdata_q <= prdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // divider control

  srfd_state_e  state_q, state_d;
  logic [7:0]   active_q, active_d;
  logic         out_q, out_d;
  logic         pd;
  logic         run;
  logic         terminal;
  logic [5:0]   tick;
  srfd_ratios_s ratios;
  srfd_ratio_t  ratio_arr [5];

  assign pd             = power_q[`SRFD_PD_BIT];
  assign run            = (state_q == ST_RUN);
  assign tick[0]        = run;
  assign terminal       = tick[5];
  assign sysref_out     = out_q;
  assign sysref_powered = run;
  assign status.active  = active_q;
  assign status.running = run;
  assign status.level   = out_q;

  srfd_decode u_decode (
    .setting (active_q),
    .ratios  (ratios)
  );

  assign ratio_arr[0] = ratios.low;
  assign ratio_arr[1] = ratios.bit2;
  assign ratio_arr[2] = ratios.bit3;
  assign ratio_arr[3] = ratios.upper;
  assign ratio_arr[4] = ratios.top;

  // stage 0 advances every running clock; each later stage advances once per terminal tick of the stage below
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_stage
      srfd_stage u_stage (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!run),
        .tick_i  (tick[gi]),
        .ratio   (ratio_arr[gi]),
        .tick_o  (tick[gi+1])
      );
    end
  endgenerate

  always_comb begin
    state_d  = pd ? ST_OFF : ST_RUN;
    active_d = active_q;
    out_d    = out_q;
    case (state_q)
      ST_OFF: begin
        active_d = divide_q;
        out_d    = 1'b0;
      end
      ST_RUN: begin
        if (terminal) begin
          out_d = !out_q;
          // only reload at the rising edge; all stages wrap to zero together
          if (!out_q) begin
            active_d = divide_q;
          end
        end
      end
      default: begin
        out_d = 1'b0;
      end
    endcase
    if (pd) begin
      out_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_OFF;
      active_q <= `SRFD_RST_DIVIDE;
      out_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      active_q <= active_d;
      out_q    <= out_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] per_cnt_q, per_cnt_d;
  logic [15:0] per_exp_q, per_exp_d;
  logic        per_ok_q, per_ok_d;
  logic        out_prev_q;
  logic [15:0] product;

  // full ratio of the active setting, for the period check
  assign product = `SRFD_FINAL_DIV * 16'(ratios.top) * 16'(ratios.upper)
                 * 16'(ratios.bit3) * 16'(ratios.bit2) * 16'(ratios.low);

  always_comb begin
    per_cnt_d = 16'(per_cnt_q + 16'h1);
    per_exp_d = per_exp_q;
    per_ok_d  = per_ok_q;
    if (!run) begin
      per_ok_d = 1'b0;
    end else if (out_q && !out_prev_q) begin
      per_cnt_d = 16'h1;
      per_exp_d = product;
      per_ok_d  = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 16'h0;
      per_exp_q <= 16'h0;
      per_ok_q  <= 1'b0;
      out_prev_q <= 1'b0;
    end else begin
      per_cnt_q <= per_cnt_d;
      per_exp_q <= per_exp_d;
      per_ok_q  <= per_ok_d;
      out_prev_q <= out_q;
    end
  end

  property p_period;
    @(posedge pclk) disable iff (!presetn)
    (run && per_ok_q && $rose(out_q)) |-> (per_cnt_q == per_exp_q);
  endproperty
  a_period: assert property (p_period) else $error("output period wrong");

  property p_default_64;
    @(posedge pclk) disable iff (!presetn)
    (active_q == 8'h00) |-> (product == 16'h0040);
  endproperty
  a_default_64: assert property (p_default_64) else $error("default ratio not 64");

  property p_top_ratio;
    @(posedge pclk) disable iff (!presetn)
    (active_q[7:6] == 2'h3) |-> (ratios.top == 5'h10);
  endproperty
  a_top_ratio: assert property (p_top_ratio) else $error("top stage not 16");

  property p_upper_ratio;
    @(posedge pclk) disable iff (!presetn)
    (active_q[5:4] == 2'h3) |-> (ratios.upper == 5'h05);
  endproperty
  a_upper_ratio: assert property (p_upper_ratio) else $error("upper stage not 5");

  property p_bit_ratio;
    @(posedge pclk) disable iff (!presetn)
    active_q[3] |-> (ratios.bit3 == 5'h04) && (active_q[2] || ratios.bit2 == 5'h02);
  endproperty
  a_bit_ratio: assert property (p_bit_ratio) else $error("single-bit stage wrong");

  property p_bit2_ratio;
    @(posedge pclk) disable iff (!presetn)
    active_q[2] |-> (ratios.bit2 == 5'h04);
  endproperty
  a_bit2_ratio: assert property (p_bit2_ratio) else $error("bit 2 stage not 4");

  property p_low_ratio;
    @(posedge pclk) disable iff (!presetn)
    (active_q[1:0] == 2'h3) |-> (ratios.low == 5'h05);
  endproperty
  a_low_ratio: assert property (p_low_ratio) else $error("low stage not 5");

  property p_pd_stop;
    @(posedge pclk) disable iff (!presetn)
    pd |=> (!out_q && !run);
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("divider runs in power down");

  property p_pd_run;
    @(posedge pclk) disable iff (!presetn)
    ((presetn && !pd) ##1 !pd) |-> run;
  endproperty
  a_pd_run: assert property (p_pd_run) else $error("divider not running");

  property p_load_boundary;
    @(posedge pclk) disable iff (!presetn)
    (run && $past(run) && (active_q != $past(active_q))) |-> ($rose(out_q));
  endproperty
  a_load_boundary: assert property (p_load_boundary) else $error("setting off boundary");

endmodule

// ### unused.sv
`timescale 1ns/100ps

// ### sysref_frequency_divider_test.sv
`timescale 1ns/100ps
`include "srfd_map.svh"

module sysref_frequency_divider_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref_out;
  logic        sysref_powered;
  int          err_count;
  int          num_checks;
  int          runs[$];
  int          run;
  logic        last;

  srfd_top u_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .sysref_out     (sysref_out),
    .sysref_powered (sysref_powered)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // run lengths of each output level, in clock samples
  always @(posedge pclk) begin
    if (sysref_out === last) begin
      run <= run + 1;
    end else begin
      runs.push_back(run);
      run <= 1;
    end
    last <= sysref_out;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_int(input int got, input int exp, input string msg);
    num_checks++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  // wait states are allowed: access lasts until pready is sampled high, for up to 100 clocks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk_int(n, 0, "pready timeout");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic write_reg(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk_word({31'h0, er}, {31'h0, ee}, "write pslverr");
  endtask

  task automatic read_reg(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk_word({31'h0, er}, {31'h0, ee}, "read pslverr");
    chk_word(rd, exp, "read data");
  endtask

  function automatic int half(input logic [7:0] s);
    return (2 << s[7:6]) * (s[5:4] + 2) * (s[3] ? 4 : 2) * (s[2] ? 4 : 2) * (s[1:0] + 2);
  endfunction

  task automatic sync_rise;
    int n;
    n = 0;
    while (sysref_out !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    while (sysref_out !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) chk_int(n, 0, "no rising edge");
    #1 runs.delete();
  endtask

  task automatic wait_runs(input int k);
    int n;
    n = 0;
    while (runs.size() < k && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40000) chk_int(runs.size(), k, "run count");
  endtask

  ////////////////////////////////////////////////////////////////////////
  logic [11:0] rst_a[7] = '{12'h060, 12'h064, 12'h068, 12'h06c, 12'h070, 12'h07c, 12'h1c0};
  logic [7:0]  rst_v[7] = '{8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // every code of every field, all-ones last as the longest ratio
  // 8'hd3 is the preferred coding of 1920: top field 16, upper field 3, low field 5
  logic [7:0]  sets[13] = '{8'h40, 8'h80, 8'hc0, 8'h10, 8'h20, 8'h30,
                            8'h08, 8'h04, 8'h01, 8'h02, 8'h03, 8'hd3, 8'hff};
  int          old_p;

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_count = 0;
    num_checks = 0;
    run = 0;
    last = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) read_reg(rst_a[i], {24'h0, rst_v[i]}, 1'b0);
    chk_word({31'h0, sysref_powered}, 32'h1, "powered after reset");
    for (int i = 2; i < 6; i++) begin
      write_reg(rst_a[i], 32'ha5, 1'b0);
      read_reg(rst_a[i], 32'ha5, 1'b0);
    end
    write_reg(12'h070, 32'hff, 1'b0);
    read_reg(12'h070, {24'h0, `SRFD_MASK_MODHI}, 1'b0);
    write_reg(12'h1c0, 32'hff, 1'b0);
    read_reg(12'h1c0, {24'h0, `SRFD_MASK_SINGLE}, 1'b0);
    read_reg(12'h100, 32'h0, 1'b1);
    write_reg(12'h061, 32'h12, 1'b1);
    write_reg(12'h1c4, 32'hff, 1'b0);
    sync_rise();
    wait_runs(2);
    chk_int(runs[0], 32, "default high");
    chk_int(runs[1], 32, "default low");
    old_p = 32;
    foreach (sets[i]) begin
      sync_rise();
      // written mid-high: the running period must finish at the old ratio
      write_reg(12'h060, {24'h0, sets[i]}, 1'b0);
      wait_runs(4);
      chk_int(runs[0], old_p, "old high kept");
      chk_int(runs[1], old_p, "old low kept");
      chk_int(runs[2], half(sets[i]), "new high");
      chk_int(runs[3], half(sets[i]), "new low");
      old_p = half(sets[i]);
    end
    sync_rise();
    write_reg(12'h064, 32'hc4, 1'b0);
    @(posedge pclk);
    #1 chk_word({30'h0, sysref_out, sysref_powered}, 32'h0, "powered down");
    write_reg(12'h060, 32'h01, 1'b0);
    read_reg(12'h1c4, 32'h004, 1'b0);
    repeat (100) @(posedge pclk);
    #1 chk_word({30'h0, sysref_out, sysref_powered}, 32'h0, "stays down");
    write_reg(12'h064, 32'h44, 1'b0);
    @(posedge pclk);
    #1 chk_word({31'h0, sysref_powered}, 32'h1, "powered up");
    sync_rise();
    wait_runs(2);
    chk_int(runs[0], 48, "restart high");
    chk_int(runs[1], 48, "restart low");
    stop_test();
  end

  initial begin
    #400000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
